// ### dv/hsp_host_model.sv
`timescale 1ns/1ps
module hsp_host_model (
    input  wire logic clk,
    input  wire logic serial_out,
    input  wire logic serial_out_oe,
    output logic      cs_n,
    output logic      serial_in,
    output logic      sclk
);
    initial begin
        cs_n = 1'b1;
        serial_in  = 1'b0;
        sclk = 1'b0;
    end

    // half of a 160 ns serial clock period
    task automatic half();
        repeat (20) @(posedge clk);
    endtask

    // hardware mode: the same lines as static levels {ch1, ch0, coder}
    task automatic set_static(input logic [2:0] v);
        cs_n <= v[0];
        serial_in  <= v[1];
        sclk <= v[2];
    endtask

    task automatic frame(input logic rw, input logic [4:0] a, input logic [7:0] d,
                         input logic sel_n, output logic [7:0] rd);
        logic [13:0] sh;
        sh = {rw, a, d};
        rd = 8'h00;
        sclk <= 1'b0;
        cs_n <= sel_n;
        half();
        for (int i = 13; i >= 0; i--) begin
            serial_in <= sh[i];
            half();
            sclk <= 1'b1;
            // released line reads as the inverse, so an early sample shows up
            rd = {rd[6:0], serial_out_oe ? serial_out : ~serial_out};
            half();
            sclk <= 1'b0;
        end
        half();
        cs_n <= 1'b1;
        serial_in  <= ~sh[0];
        half();
    endtask
endmodule

// ### dv/testbench.sv
`timescale 1ns/1ps
module testbench;
    import hsp_pkg::*;
    logic        clk, nrst, psel, penable, pwrite, pready, pslverr, rx2, pinv;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, st;
    logic        cs_n, serial_in, sclk, sout, soe, lcd, rinv;
    logic [2:0]  rxs, cdr_clock, cdr_pos, cdr_neg, rclk, rpos, rneg;
    logic [33:0] q[$];
    logic [33:0] e_m;
    logic [31:0] v, d;
    logic [7:0]  rd;
    int          n_mismatch, n_compared;

    hsp_top u_hsp_top (.clk(clk), .nrst(nrst), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .cs_n_coder_disable(cs_n),
        .serial_in_rx_shutdown_ch0(serial_in), .sclk_rx_shutdown_ch1(sclk),
        .rx_shutdown_ch2(rx2), .cmd_reg_reset_n_clock_invert(pinv),
        .serial_out(sout), .serial_out_oe(soe), .line_coder_disable(lcd),
        .rx_shutdown(rxs), .recovered_clock_invert(rinv), .cdr_clock(cdr_clock),
        .cdr_pos(cdr_pos), .cdr_neg(cdr_neg), .recovered_clock(rclk),
        .recovered_pos_rail(rpos), .recovered_neg_rail(rneg));
    hsp_host_model u_hsp_host_model (.clk(clk), .serial_out(sout), .serial_out_oe(soe),
        .cs_n(cs_n), .serial_in(serial_in), .sclk(sclk));

    function automatic logic [31:0] xs();
        st = st ^ (st << 13);
        st = st ^ (st >> 17);
        st = st ^ (st << 5);
        return st;
    endfunction

    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        n_compared++;
        if (s !== e) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic wrap_up();
        if (n_mismatch == 0 && n_compared > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    // e: [33] compare data, [32] expected error, [31:0] expected data
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] wd,
                       input logic [33:0] e);
        q.push_back(e);
        paddr   <= a;
        pwrite  <= w;
        pwdata  <= wd;
        psel    <= 1'b1;
        penable <= 1'b0;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic cfg_chk(input logic [4:0] c);
        chk("line_coder_disable", lcd, c[0]);
        chk("rx_shutdown", rxs, c[3:1]);
        chk("recovered_clock_invert", rinv, c[4]);
    endtask

    always @(posedge clk) begin
        if (psel && penable && pready === 1'b1) begin
            e_m = q.pop_front();
            chk("pslverr", pslverr, e_m[32]);
            if (e_m[33]) chk("prdata", prdata, e_m[31:0]);
        end
    end

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        wrap_up();
    end

    initial begin
        st = 32'h000117F9;
        {nrst, psel, penable, pwrite, paddr, pwdata} = '0;
        {rx2, pinv, cdr_clock, cdr_pos, cdr_neg} = '0;
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        apb(OFS_CTRL, 1'b0, 32'h0, {2'b10, 32'h0});
        apb(8'h0C, 1'b0, 32'h0, {2'b11, 32'h0});
        apb(OFS_STATUS, 1'b1, 32'h1F, {2'b00, 32'h0});
        for (int i = 0; i < 8; i++) begin
            v = xs();
            u_hsp_host_model.set_static(v[2:0]);
            rx2       <= v[3];
            pinv      <= v[4];
            cdr_clock <= 3'h0;
            cdr_pos   <= v[10:8];
            cdr_neg   <= v[13:11];
            repeat (8) @(posedge clk);
            cfg_chk(v[4:0]);
            chk("recovered_clock", rclk, {3{v[4]}});
            cdr_clock <= 3'h7;
            repeat (8) @(posedge clk);
            chk("recovered_clock", rclk, 3'h7 ^ {3{v[4]}});
            chk("recovered_pos_rail", rpos, v[10:8]);
            chk("recovered_neg_rail", rneg, v[13:11]);
            apb(OFS_STATUS, 1'b0, 32'h0, {2'b10, 27'h0, v[4:0]});
        end
        pinv <= 1'b1;
        u_hsp_host_model.set_static(3'b001);
        apb(OFS_CTRL, 1'b1, 32'h1, {2'b00, 32'h0});
        d = xs() | 32'h00000001;
        v = xs() | 32'h00000001;
        u_hsp_host_model.frame(1'b0, 5'h07, 8'hA5, 1'b1, rd);
        u_hsp_host_model.frame(1'b0, 5'h03, d[7:0], 1'b0, rd);
        u_hsp_host_model.frame(1'b0, 5'h00, {3'h0, v[4:0]}, 1'b0, rd);
        u_hsp_host_model.frame(RW_READ, 5'h03, 8'h5A, 1'b0, rd);
        chk("serial read", rd, d[7:0]);
        chk("serial_out_oe", soe, 32'h0);
        u_hsp_host_model.frame(RW_READ, 5'h07, 8'h3C, 1'b0, rd);
        chk("ignored write", rd, 8'h00);
        cfg_chk(v[4:0]);
        apb(OFS_FRAMES, 1'b0, 32'h0, {2'b10, 32'h4});
        pinv <= 1'b0;
        repeat (8) @(posedge clk);
        pinv <= 1'b1;
        repeat (8) @(posedge clk);
        cfg_chk(5'h00);
        u_hsp_host_model.frame(RW_READ, 5'h03, 8'hC3, 1'b0, rd);
        chk("cleared entry", rd, 8'h00);
        wrap_up();
    end
endmodule

// ### src/hsp_cmd_mem.sv
`timescale 1ns/1ps
module hsp_cmd_mem #(
    parameter int             AW      = hsp_pkg::CMD_AW,
    parameter int             DW      = hsp_pkg::CMD_DW,
    parameter logic [DW-1:0]  RST_VAL = hsp_pkg::CMD_DEFAULT
) (
    input  wire logic          clk,
    input  wire logic          nrst,
    input  wire logic          clear,
    input  wire logic          we,
    input  wire logic [AW-1:0] waddr,
    input  wire logic [DW-1:0] wdata,
    input  wire logic          re,
    input  wire logic [AW-1:0] raddr,
    output logic      [DW-1:0] rdata,
    output logic      [DW-1:0] word0
);
    import hsp_pkg::*;

    logic [DW-1:0] ent [2**AW];
    logic [DW-1:0] rdata_reg;
    logic [DW-1:0] rdata_next;

    for (genvar i = 0; i < 2**AW; i++) begin : g_ent
        logic [DW-1:0] q_reg;
        logic [DW-1:0] q_next;
        always_comb begin
            q_next = q_reg;
            if (clear) begin
                q_next = RST_VAL;
            end else if (we && waddr == AW'(i)) begin
                q_next = wdata;
            end
        end
        always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
                q_reg <= RST_VAL;
            end else begin
                q_reg <= q_next;
            end
        end
        assign ent[i] = q_reg;
    end

    always_comb begin
        rdata_next = re ? ent[raddr] : rdata_reg;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rdata_reg <= RST_VAL;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    assign rdata = rdata_reg;
    assign word0 = ent[0];
endmodule

// ### src/hsp_pkg.sv
package hsp_pkg;
    // register bus
    localparam int         APB_AW        = 8;
    localparam int         APB_DW        = 32;
    localparam logic [7:0] OFS_CTRL      = 8'h00;
    localparam logic [7:0] OFS_STATUS    = 8'h04;
    localparam logic [7:0] OFS_FRAMES    = 8'h08;
    localparam int         CTRL_HOST_BIT = 0;
    localparam logic       CTRL_HOST_RST = 1'b0;
    localparam int         ST_CODER_BIT  = 0;
    localparam int         ST_RXOFF_LSB  = 1;
    localparam int         ST_INV_BIT    = 4;
    localparam int         ST_BUSY_BIT   = 5;
    localparam int         FRAME_CW      = 8;

    // channels and serial command port
    localparam int         NCH           = 3;
    localparam int         CMD_AW        = 5;
    localparam int         CMD_DW        = 8;
    localparam int         CNT_W         = 4;
    localparam logic [7:0] CMD_DEFAULT   = 8'h00;
    localparam int         CFG_CODER_BIT = 0;
    localparam int         CFG_RXOFF_LSB = 1;
    localparam int         CFG_INV_BIT   = 4;
    localparam logic       RW_READ       = 1'b1;

    // synchronised pin vector layout
    localparam int          PIN_CS      = 0;
    localparam int          PIN_SDI     = 1;
    localparam int          PIN_SCLK    = 2;
    localparam int          PIN_RX2     = 3;
    localparam int          PIN_CMD_REG_RESET_N    = 4;
    localparam int          PIN_CLK_LSB = 5;
    localparam int          PIN_POS_LSB = 8;
    localparam int          PIN_NEG_LSB = 11;
    localparam int          NPIN        = 14;
    // select and register-reset pins idle high
    localparam logic [13:0] SYNC_RST    = 14'h0011;

    typedef enum logic [4:0] {
        SP_IDLE  = 5'b00001,
        SP_ADDR  = 5'b00010,
        SP_WDATA = 5'b00100,
        SP_RDATA = 5'b01000,
        SP_DONE  = 5'b10000
    } hsp_sp_state_t;
endpackage

// ### src/hsp_top.sv
// Implementation choices: the address map and the APB interface to the registers.
`timescale 1ns/1ps
// Summary of operation
// - host mode: serial port; hardware mode: static config
// - coder-disable high gives plain AMI coding
// - coder-disable low enables zero-substitution coder
// - one coder-disable bit serves all channels
// - serial input sampled on serial clock rise
// - read data driven out on serial clock fall
// - channel 0 receiver off when its pin high
// - channel 1 receiver off when its pin high
// - channel 2 receiver off when its pin high
// - register-reset low restores command register defaults
// - invert high: inverted clock, data on falling edge
// - invert low: data launched on clock rising edge
module hsp_top (
    input  wire logic                       clk,
    input  wire logic                       nrst,
    input  wire logic [hsp_pkg::APB_AW-1:0] paddr,
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [hsp_pkg::APB_DW-1:0] pwdata,
    output logic      [hsp_pkg::APB_DW-1:0] prdata,
    output logic                            pready,
    output logic                            pslverr,
    input  wire logic                       cs_n_coder_disable,
    input  wire logic                       serial_in_rx_shutdown_ch0,
    input  wire logic                       sclk_rx_shutdown_ch1,
    input  wire logic                       rx_shutdown_ch2,
    input  wire logic                       cmd_reg_reset_n_clock_invert,
    output logic                            serial_out,
    output logic                            serial_out_oe,
    output logic                            line_coder_disable,
    output logic      [hsp_pkg::NCH-1:0]    rx_shutdown,
    output logic                            recovered_clock_invert,
    input  wire logic [hsp_pkg::NCH-1:0]    cdr_clock,
    input  wire logic [hsp_pkg::NCH-1:0]    cdr_pos,
    input  wire logic [hsp_pkg::NCH-1:0]    cdr_neg,
    output logic      [hsp_pkg::NCH-1:0]    recovered_clock,
    output logic      [hsp_pkg::NCH-1:0]    recovered_pos_rail,
    output logic      [hsp_pkg::NCH-1:0]    recovered_neg_rail
);
    import hsp_pkg::*;

    // pin synchronisers
    logic [NPIN-1:0] pin_raw;
    logic [NPIN-1:0] s1_reg;
    logic [NPIN-1:0] s2_reg;
    logic [NPIN-1:0] last_reg;

    assign pin_raw = {cdr_neg, cdr_pos, cdr_clock, cmd_reg_reset_n_clock_invert,
                      rx_shutdown_ch2, sclk_rx_shutdown_ch1,
                      serial_in_rx_shutdown_ch0, cs_n_coder_disable};

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s1_reg   <= SYNC_RST;
            s2_reg   <= SYNC_RST;
            last_reg <= SYNC_RST;
        end else begin
            s1_reg   <= pin_raw;
            s2_reg   <= s1_reg;
            last_reg <= s2_reg;
        end
    end

    logic cs_s;
    logic sdi_s;
    logic sclk_s;
    logic rx2_s;
    logic cmd_reg_reset_n_s;
    logic sclk_rise;
    logic sclk_fall;

    assign cs_s   = s2_reg[PIN_CS];
    assign sdi_s  = s2_reg[PIN_SDI];
    assign sclk_s = s2_reg[PIN_SCLK];
    assign rx2_s  = s2_reg[PIN_RX2];
    assign cmd_reg_reset_n_s = s2_reg[PIN_CMD_REG_RESET_N];

    logic host_mode_reg;
    logic host_mode_next;

    assign sclk_rise = host_mode_reg && !cs_s && sclk_s && !last_reg[PIN_SCLK];
    assign sclk_fall = host_mode_reg && !cs_s && !sclk_s && last_reg[PIN_SCLK];

    // command register file
    logic              mem_we;
    logic              mem_re;
    logic              mem_clear;
    logic [CMD_DW-1:0] mem_rdata;
    logic [CMD_DW-1:0] cmd_word0;
    logic [CMD_AW-1:0] addr_reg;
    logic [CMD_AW-1:0] addr_next;
    logic [CMD_DW-1:0] sh_reg;
    logic [CMD_DW-1:0] sh_next;

    assign mem_clear = host_mode_reg && !cmd_reg_reset_n_s;

    hsp_cmd_mem #(
        .AW      (CMD_AW),
        .DW      (CMD_DW),
        .RST_VAL (CMD_DEFAULT)
    ) u_mem (
        .clk   (clk),
        .nrst  (nrst),
        .clear (mem_clear),
        .we    (mem_we),
        .waddr (addr_reg),
        .wdata ({sh_reg[CMD_DW-2:0], sdi_s}),
        .re    (mem_re),
        .raddr (addr_next),
        .rdata (mem_rdata),
        .word0 (cmd_word0)
    );

    // serial command port
    hsp_sp_state_t       st_reg;
    hsp_sp_state_t       st_next;
    logic [CNT_W-1:0]    cnt_reg;
    logic [CNT_W-1:0]    cnt_next;
    logic                rw_reg;
    logic                rw_next;
    logic [CMD_DW-1:0]   osh_reg;
    logic [CMD_DW-1:0]   osh_next;
    logic                sout_reg;
    logic                sout_next;
    logic                soe_reg;
    logic                soe_next;
    logic                rd_pend_reg;
    logic                rd_pend_next;
    logic [FRAME_CW-1:0] frames_reg;
    logic [FRAME_CW-1:0] frames_next;

    always_comb begin
        st_next      = st_reg;
        cnt_next     = cnt_reg;
        rw_next      = rw_reg;
        addr_next    = addr_reg;
        sh_next      = sh_reg;
        osh_next     = rd_pend_reg ? mem_rdata : osh_reg;
        sout_next    = sout_reg;
        soe_next     = soe_reg;
        rd_pend_next = 1'b0;
        frames_next  = frames_reg;
        mem_we       = 1'b0;
        mem_re       = 1'b0;
        if (!host_mode_reg || cs_s) begin
            st_next  = SP_IDLE;
            cnt_next = '0;
            soe_next = 1'b0;
        end else begin
            case (st_reg)
                SP_IDLE: begin
                    if (sclk_rise) begin
                        rw_next  = sdi_s;
                        cnt_next = '0;
                        st_next  = SP_ADDR;
                    end
                end
                SP_ADDR: begin
                    if (sclk_rise) begin
                        addr_next = {addr_reg[CMD_AW-2:0], sdi_s};
                        cnt_next  = cnt_reg + 1'b1;
                        if (cnt_reg == CNT_W'(CMD_AW - 1)) begin
                            cnt_next = '0;
                            if (rw_reg == RW_READ) begin
                                mem_re       = 1'b1;
                                rd_pend_next = 1'b1;
                                st_next      = SP_RDATA;
                            end else begin
                                st_next = SP_WDATA;
                            end
                        end
                    end
                end
                SP_WDATA: begin
                    if (sclk_rise) begin
                        sh_next  = {sh_reg[CMD_DW-2:0], sdi_s};
                        cnt_next = cnt_reg + 1'b1;
                        if (cnt_reg == CNT_W'(CMD_DW - 1)) begin
                            mem_we      = 1'b1;
                            frames_next = frames_reg + 1'b1;
                            st_next     = SP_DONE;
                        end
                    end
                end
                SP_RDATA: begin
                    if (sclk_fall) begin
                        sout_next = osh_reg[CMD_DW-1];
                        osh_next  = {osh_reg[CMD_DW-2:0], 1'b0};
                        soe_next  = 1'b1;
                        cnt_next  = cnt_reg + 1'b1;
                        if (cnt_reg == CNT_W'(CMD_DW - 1)) begin
                            frames_next = frames_reg + 1'b1;
                            st_next     = SP_DONE;
                        end
                    end
                end
                SP_DONE: begin
                    st_next = SP_DONE;
                end
                default: begin
                    st_next = SP_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_reg      <= SP_IDLE;
            cnt_reg     <= '0;
            rw_reg      <= 1'b0;
            addr_reg    <= '0;
            sh_reg      <= '0;
            osh_reg     <= '0;
            sout_reg    <= 1'b0;
            soe_reg     <= 1'b0;
            rd_pend_reg <= 1'b0;
            frames_reg  <= '0;
        end else begin
            st_reg      <= st_next;
            cnt_reg     <= cnt_next;
            rw_reg      <= rw_next;
            addr_reg    <= addr_next;
            sh_reg      <= sh_next;
            osh_reg     <= osh_next;
            sout_reg    <= sout_next;
            soe_reg     <= soe_next;
            rd_pend_reg <= rd_pend_next;
            frames_reg  <= frames_next;
        end
    end

    // static configuration select
    logic           coder_reg;
    logic           coder_next;
    logic [NCH-1:0] rxoff_reg;
    logic [NCH-1:0] rxoff_next;
    logic           inv_reg;
    logic           inv_next;

    always_comb begin
        if (host_mode_reg) begin
            coder_next = cmd_word0[CFG_CODER_BIT];
            rxoff_next = cmd_word0[CFG_RXOFF_LSB +: NCH];
            inv_next   = cmd_word0[CFG_INV_BIT];
        end else begin
            coder_next = cs_s;
            rxoff_next = {rx2_s, sclk_s, sdi_s};
            inv_next   = cmd_reg_reset_n_s;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            coder_reg <= 1'b0;
            rxoff_reg <= '0;
            inv_reg   <= 1'b0;
        end else begin
            coder_reg <= coder_next;
            rxoff_reg <= rxoff_next;
            inv_reg   <= inv_next;
        end
    end

    // recovered clock and rail launch per channel
    for (genvar c = 0; c < NCH; c++) begin : g_ch
        logic rise;
        logic clk_reg;
        logic clk_next;
        logic pos_reg;
        logic pos_next;
        logic neg_reg;
        logic neg_next;

        assign rise = s2_reg[PIN_CLK_LSB+c] && !last_reg[PIN_CLK_LSB+c];

        always_comb begin
            clk_next = s2_reg[PIN_CLK_LSB+c] ^ inv_reg;
            pos_next = rise ? s2_reg[PIN_POS_LSB+c] : pos_reg;
            neg_next = rise ? s2_reg[PIN_NEG_LSB+c] : neg_reg;
        end

        always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
                clk_reg <= 1'b0;
                pos_reg <= 1'b0;
                neg_reg <= 1'b0;
            end else begin
                clk_reg <= clk_next;
                pos_reg <= pos_next;
                neg_reg <= neg_next;
            end
        end

        assign recovered_clock[c]    = clk_reg;
        assign recovered_pos_rail[c] = pos_reg;
        assign recovered_neg_rail[c] = neg_reg;
    end

    // apb slave, no wait states
    logic              setup;
    logic              access;
    logic              mapped;
    logic [APB_DW-1:0] rd_val;
    logic [APB_DW-1:0] prdata_reg;
    logic [APB_DW-1:0] prdata_next;
    logic              pready_reg;
    logic              pready_next;
    logic              pslverr_reg;
    logic              pslverr_next;

    assign setup  = psel && !penable;
    assign access = psel && penable && pready_reg;

    always_comb begin
        rd_val = '0;
        mapped = 1'b1;
        case (paddr)
            OFS_CTRL: rd_val[CTRL_HOST_BIT] = host_mode_reg;
            OFS_STATUS: begin
                rd_val[ST_CODER_BIT]             = coder_reg;
                rd_val[ST_RXOFF_LSB +: NCH]      = rxoff_reg;
                rd_val[ST_INV_BIT]               = inv_reg;
                rd_val[ST_BUSY_BIT]              = st_reg != SP_IDLE;
            end
            OFS_FRAMES: rd_val[FRAME_CW-1:0] = frames_reg;
            default: mapped = 1'b0;
        endcase
        pready_next    = setup;
        pslverr_next   = setup && !mapped;
        prdata_next    = setup ? rd_val : prdata_reg;
        host_mode_next = host_mode_reg;
        if (access && pwrite && paddr == OFS_CTRL) begin
            host_mode_next = pwdata[CTRL_HOST_BIT];
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            prdata_reg    <= '0;
            pready_reg    <= 1'b0;
            pslverr_reg   <= 1'b0;
            host_mode_reg <= CTRL_HOST_RST;
        end else begin
            prdata_reg    <= prdata_next;
            pready_reg    <= pready_next;
            pslverr_reg   <= pslverr_next;
            host_mode_reg <= host_mode_next;
        end
    end

    assign prdata                 = prdata_reg;
    assign pready                 = pready_reg;
    assign pslverr                = pslverr_reg;
    assign serial_out             = sout_reg;
    assign serial_out_oe          = soe_reg;
    assign line_coder_disable     = coder_reg;
    assign rx_shutdown            = rxoff_reg;
    assign recovered_clock_invert = inv_reg;

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    sequence hw_mode_s;
        !host_mode_reg && !$past(host_mode_reg);
    endsequence

    sequence rd_launch_s;
        st_reg == SP_RDATA ##0 sclk_fall;
    endsequence

    host_cfg_a: assert property (host_mode_reg |=>
        line_coder_disable == $past(cmd_word0[CFG_CODER_BIT]))
        else $error("host mode coder select wrong");
    coder_off_a: assert property ((hw_mode_s ##0 cs_s) |=> line_coder_disable)
        else $error("coder not disabled");
    coder_on_a: assert property ((hw_mode_s ##0 !cs_s) |=> !line_coder_disable)
        else $error("coder not enabled");
    rx_off_a: assert property (hw_mode_s |=>
        rx_shutdown == $past({rx2_s, sclk_s, sdi_s}))
        else $error("receiver shutdown mismatch");
    cs_idle_a: assert property (cs_s |=> st_reg == SP_IDLE && !serial_out_oe)
        else $error("serial active while deselected");
    sdi_rise_a: assert property ((st_reg == SP_ADDR && sclk_rise) |=>
        addr_reg[0] == $past(sdi_s))
        else $error("serial input not sampled on rise");
    sdo_fall_a: assert property (rd_launch_s |=> serial_out_oe ##0
        serial_out == $past(osh_reg[CMD_DW-1]))
        else $error("serial output not updated on fall");
    sdo_hold_a: assert property ($changed(serial_out) |-> $past(sclk_fall))
        else $error("serial output moved off a fall");
    reg_clr_a: assert property (mem_clear |=> cmd_word0 == CMD_DEFAULT)
        else $error("command registers not cleared");
    clk_inv_a: assert property (##1 recovered_clock[0] ==
        ($past(s2_reg[PIN_CLK_LSB]) ^ $past(inv_reg)))
        else $error("recovered clock polarity wrong");
    rail_edge_a: assert property ($changed(recovered_pos_rail[0]) |->
        recovered_clock[0] == !$past(inv_reg))
        else $error("rail data off its launch edge");
endmodule
